// ### hdl/memory_parity_checker.sv
// Purpose: Parity protection of the instruction memory and switch bank readback.
// Assumes: Inputs synchronous to i_clk; strobes are single-cycle or level as noted.
// Notes:   Tri-state bus drive is split into data and active-low enable.
`timescale 1ns/10ps
module memory_parity_checker
	import parity_pkg::*;
#(
	parameter int DW = parity_pkg::DATA_W,
	parameter int AW = parity_pkg::ADDR_W
) (
	// Clock and reset.
	input  wire logic          i_clk,
	input  wire logic          i_rst_b,
	// Processor memory bus.
	input  wire logic [AW-1:0] i_addr,
	input  wire logic [DW-1:0] i_data,
	input  wire logic          i_mem_select,
	input  wire logic          i_mem_write,
	input  wire logic          i_mem_read,
	input  wire logic          i_parity_sample_strobe,
	// Stored parity bits read back from the ninth memory bits.
	input  wire logic          i_parity_bank_a,
	input  wire logic          i_parity_bank_b,
	// Configuration switch banks.
	input  wire logic [7:0]    i_switch_bank_zero,
	input  wire logic [7:0]    i_switch_bank_one,
	input  wire logic          i_switch_bank_zero_read,
	input  wire logic          i_switch_bank_one_read,
	// Bank selects and ninth-bit write port.
	output logic               o_ram_bank_a_select,
	output logic               o_ram_bank_b_select,
	output logic               o_parity_write_a,
	output logic               o_parity_write_b,
	output logic               o_parity_bit,
	// Switch readback onto the data bus.
	output logic [7:0]         o_switch_data,
	output logic               o_switch_data_oe_b,
	// Status.
	output logic               o_parity_error,
	output logic               o_hold_request,
	output logic               o_halt_lamp,
	output logic               o_bootstrap_enable,
	output logic               o_parity_enable
);
	import parity_pkg::*;

	// Only an 8-bit byte and an address that reaches the bank bit are served.
	if (DW != 8 || AW <= BANK_SEL_BIT) begin : g_bad_params
		$error("memory_parity_checker: unsupported DW or AW");
	end

	// ******************************************************************
	// Parity tree and selection
	// ******************************************************************
	logic bank_b;
	logic stored_bit;
	logic tree_even;
	logic tree_odd;
	logic is_write;

	always_comb begin
		bank_b     = i_addr[BANK_SEL_BIT];
		is_write   = i_mem_select & i_mem_write;
		// Writes force the ninth input low so the tree yields the byte's parity.
		stored_bit = is_write ? 1'b0 : (bank_b ? i_parity_bank_b : i_parity_bank_a);
	end

	parity_tree #(
		.WIDTH (DW)
	) u_tree (
		.i_data  (i_data),
		.i_extra (stored_bit),
		.o_even  (tree_even),
		.o_odd   (tree_odd)
	);

	// ******************************************************************
	// Registered state
	// ******************************************************************
	logic       parity_error;
	logic       next_parity_error;
	logic       hold_request;
	logic       next_hold_request;
	logic       sel_a;
	logic       next_sel_a;
	logic       sel_b;
	logic       next_sel_b;
	logic       wr_a;
	logic       next_wr_a;
	logic       wr_b;
	logic       next_wr_b;
	logic       par_bit;
	logic       next_par_bit;
	logic [7:0] sw_data;
	logic [7:0] next_sw_data;
	logic       sw_oe_b;
	logic       next_sw_oe_b;
	logic       boot_en;
	logic       next_boot_en;
	logic       par_en;
	logic       next_par_en;

	always_comb begin
		next_par_en  = i_switch_bank_zero[SW_PARITY_POS];
		next_boot_en = i_switch_bank_zero[SW_BOOT_POS];
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			par_en  <= RST_CFG;
			boot_en <= RST_CFG;
		end else begin
			par_en  <= next_par_en;
			boot_en <= next_boot_en;
		end
	end

	// ******************************************************************
	// Bank selects and ninth-bit writes
	// ******************************************************************
	always_comb begin
		next_sel_a   = i_mem_select & ~bank_b;
		next_sel_b   = i_mem_select & bank_b;
		// Even parity: the stored bit makes the nine-bit word's ones count even.
		next_par_bit = tree_odd;
		next_wr_a    = is_write & par_en & ~bank_b;
		next_wr_b    = is_write & par_en & bank_b;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			sel_a   <= RST_STROBE;
			sel_b   <= RST_STROBE;
			wr_a    <= RST_STROBE;
			wr_b    <= RST_STROBE;
			par_bit <= RST_STROBE;
		end else begin
			sel_a   <= next_sel_a;
			sel_b   <= next_sel_b;
			wr_a    <= next_wr_a;
			wr_b    <= next_wr_b;
			par_bit <= next_par_bit;
		end
	end

	// ******************************************************************
	// Error flag and hold request
	// ******************************************************************
	always_comb begin
		// A sticky error; sampling only on a read strobe while checking is on.
		next_parity_error = parity_error;
		if (i_parity_sample_strobe && i_mem_select && i_mem_read && par_en && !tree_even) begin
			next_parity_error = 1'b1;
		end
		next_hold_request = hold_request | next_parity_error;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			parity_error <= RST_ERROR;
			hold_request <= RST_HOLD;
		end else begin
			parity_error <= next_parity_error;
			hold_request <= next_hold_request;
		end
	end

	// ******************************************************************
	// Switch bank readback
	// ******************************************************************
	always_comb begin
		// Switch drivers are enabled from the edge after a read strobe rises until the edge after it falls; bank zero wins.
		if (i_switch_bank_zero_read) begin
			next_sw_data = i_switch_bank_zero;
			next_sw_oe_b = 1'b0;
		end else if (i_switch_bank_one_read) begin
			next_sw_data = i_switch_bank_one;
			next_sw_oe_b = 1'b0;
		end else begin
			next_sw_data = RST_BYTE;
			next_sw_oe_b = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			sw_data <= RST_BYTE;
			sw_oe_b <= RST_OE_B;
		end else begin
			sw_data <= next_sw_data;
			sw_oe_b <= next_sw_oe_b;
		end
	end

	// ******************************************************************
	// Outputs
	// ******************************************************************
	always_comb begin
		o_ram_bank_a_select = sel_a;
		o_ram_bank_b_select = sel_b;
		o_parity_write_a    = wr_a;
		o_parity_write_b    = wr_b;
		o_parity_bit        = par_bit;
		o_switch_data       = sw_data;
		o_switch_data_oe_b  = sw_oe_b;
		o_parity_error      = parity_error;
		o_hold_request      = hold_request;
		o_halt_lamp         = hold_request;
		o_bootstrap_enable  = boot_en;
		o_parity_enable     = par_en;
	end
endmodule // memory_parity_checker

// ### hdl/parity_pkg.sv
// Purpose: Shared constants for the instruction memory parity checker.
// Assumes: 8-bit processor data bus, 16-bit address bus.
// Notes:   Switch positions are bit indices within a switch bank.
package parity_pkg;
	localparam int  DATA_W          = 8;
	localparam int  ADDR_W          = 16;
	localparam int  BANK_SEL_BIT    = 14;
	localparam int  SW_BOOT_POS     = 6;
	localparam int  SW_PARITY_POS   = 7;
	localparam logic RST_ERROR      = 1'b0;
	localparam logic RST_HOLD       = 1'b0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic RST_CFG        = 1'b0;
	localparam logic RST_STROBE     = 1'b0;
	localparam logic RST_OE_B       = 1'b1;
endpackage

// ### hdl/parity_tree.sv
// Purpose: Nine-input even/odd parity generator and checker.
// Assumes: Purely combinational.
// Notes:   o_even is high when the count of ones over all inputs is even.
`timescale 1ns/10ps
module parity_tree #(
	parameter int WIDTH = 8
) (
	// Data and ninth input.
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_extra,
	// Results.
	output logic                  o_even,
	output logic                  o_odd
);
	if (WIDTH < 1) begin : g_bad_width
		$error("parity_tree: WIDTH must be at least 1");
	end

	always_comb begin
		o_odd  = ^{i_extra, i_data};
		o_even = ~o_odd;
	end
endmodule // parity_tree

// ### tb/memory_parity_props.sv
// Purpose: Port assertions for the parity checker.
// Assumes: One clock, synchronous reset.
// Notes:   Outputs follow their cause by one edge.
`timescale 1ns/10ps
module memory_parity_props
	import parity_pkg::*;
#(parameter int DW = DATA_W, parameter int AW = ADDR_W) (
	input wire logic i_clk, i_rst_b, i_mem_select, i_mem_write, i_mem_read, i_parity_sample_strobe,
	input wire logic i_parity_bank_a, i_parity_bank_b, i_switch_bank_zero_read, o_ram_bank_b_select,
	input wire logic o_parity_write_a, o_parity_bit, o_switch_data_oe_b, o_parity_error,
	input wire logic o_hold_request, o_halt_lamp, o_parity_enable,
	input wire logic [AW-1:0] i_addr,
	input wire logic [DW-1:0] i_data
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	wire logic b14 = i_addr[BANK_SEL_BIT];
	wire logic par = ^i_data;
	wire logic wa = i_mem_select & i_mem_write & o_parity_enable & !b14;
	wire logic bad = i_parity_sample_strobe & i_mem_select & i_mem_read & o_parity_enable
		& (par ^ (b14 ? i_parity_bank_b : i_parity_bank_a));
	property p_sel; i_mem_select |=> o_ram_bank_b_select == $past(b14); endproperty
	a_sel: assert property (p_sel) else $error("bad bank select");
	property p_wr; 1 |=> o_parity_write_a == $past(wa); endproperty
	a_wr: assert property (p_wr) else $error("bad parity write");
	property p_bit; i_mem_select & i_mem_write |=> o_parity_bit == $past(par); endproperty
	a_bit: assert property (p_bit) else $error("bad parity bit");
	property p_err; bad |=> o_parity_error; endproperty
	a_err: assert property (p_err) else $error("error missed");
	property p_quiet; !bad & !o_parity_error |=> !o_parity_error; endproperty
	a_quiet: assert property (p_quiet) else $error("false error");
	property p_hold; o_parity_error |-> o_hold_request [*2]; endproperty
	a_hold: assert property (p_hold) else $error("hold dropped");
	property p_lamp; o_halt_lamp == o_hold_request; endproperty
	a_lamp: assert property (p_lamp) else $error("bad lamp");
	property p_sw; i_switch_bank_zero_read |=> !o_switch_data_oe_b; endproperty
	a_sw: assert property (p_sw) else $error("switch not driven");
	c_err: cover property (bad);
	c_wr: cover property (wa);
	c_sw: cover property (i_switch_bank_zero_read);
endmodule // memory_parity_props
bind memory_parity_checker memory_parity_props #(.DW(DW), .AW(AW)) i_memory_parity_props(.*);

// ### tb/parity_mem_model.sv
// Purpose: Stored ninth bits of banks A and B.
// Assumes: One cell per bank suffices here.
// Notes:   i_flip corrupts the read-back bit.
`timescale 1ns/10ps
module parity_mem_model (
	input  wire logic i_clk, i_write_a, i_write_b, i_bit, i_flip,
	output logic      o_bank_a, o_bank_b
);
	logic cell_a = 1'b0, cell_b = 1'b0;
	always_ff @(posedge i_clk) begin
		if (i_write_a) cell_a <= i_bit;
		if (i_write_b) cell_b <= i_bit;
	end
	assign o_bank_a = cell_a ^ i_flip;
	assign o_bank_b = cell_b ^ i_flip;
endmodule // parity_mem_model

// ### tb/test_memory_parity_checker.sv
// Purpose: Self-checking bench.
// Assumes: Outputs answer one edge late.
// Notes:   Inputs change at rising edges.
`timescale 1ns/10ps
module test_memory_parity_checker;
	import parity_pkg::*;
	logic i_clk = 0, i_rst_b = 0, i_mem_select = 0, i_mem_write = 0, i_mem_read = 0, flip = 0;
	logic i_parity_sample_strobe = 0, i_switch_bank_zero_read = 0, i_switch_bank_one_read = 0;
	logic i_parity_bank_a, i_parity_bank_b, o_ram_bank_a_select, o_ram_bank_b_select, o_parity_write_a;
	logic o_parity_write_b, o_parity_bit, o_switch_data_oe_b, o_parity_error, o_hold_request;
	logic o_halt_lamp, o_bootstrap_enable, o_parity_enable;
	logic [15:0] i_addr = 16'h0000;
	logic [7:0]  i_data = 8'h00, i_switch_bank_zero = 8'h5A, i_switch_bank_one = 8'hA5, o_switch_data;
	int          bad_count = 0, n_compared = 0;
	initial forever #2.5 i_clk = ~i_clk;
	memory_parity_checker i_memory_parity_checker(.*);
	parity_mem_model i_parity_mem_model(.i_clk, .i_write_a(o_parity_write_a), .i_write_b(o_parity_write_b),
		.i_bit(o_parity_bit), .i_flip(flip), .o_bank_a(i_parity_bank_a), .o_bank_b(i_parity_bank_b));
	task automatic check(string s, logic [7:0] seen, want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", s, want, seen);
		end
	endtask
	task automatic cyc(logic [15:0] a, logic [7:0] d, logic w, r, s);
		@(posedge i_clk);
		{i_addr, i_data, i_mem_write, i_mem_read, i_parity_sample_strobe, i_mem_select} <= {a, d, w, r, s, w | r};
		@(posedge i_clk);
		{i_mem_write, i_mem_read, i_parity_sample_strobe, i_mem_select} <= 4'h0;
		#1;
	endtask
	task automatic do_reset;
		i_rst_b <= 0;
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1;
		cyc(16'h0000, 8'h00, 0, 0, 0);
		check("reset", {o_parity_error, o_hold_request, o_switch_data_oe_b}, 8'h01);
	endtask
	task automatic t_switch;
		@(posedge i_clk) i_switch_bank_zero_read <= 1;
		@(posedge i_clk) {i_switch_bank_zero_read, i_switch_bank_one_read} <= 2'b01;
		#1 check("bank0", o_switch_data, 8'h5A);
		check("oe", o_switch_data_oe_b, 8'h00);
		check("cfg", {o_parity_enable, o_bootstrap_enable}, 8'h01);
		@(posedge i_clk) i_switch_bank_one_read <= 0;
		#1 check("bank1", o_switch_data, 8'hA5);
		@(posedge i_clk);
		#1 check("oe", o_switch_data_oe_b, 8'h01);
		$display("switch test done");
	endtask
	task automatic t_off;
		cyc(16'h0000, 8'h07, 1, 0, 0);
		check("wr", {o_ram_bank_a_select, o_ram_bank_b_select, o_parity_write_a}, 8'h04);
		flip <= 1;
		cyc(16'h0000, 8'h00, 0, 1, 1);
		check("err", o_parity_error, 8'h00);
		flip <= 0;
		$display("disabled test done");
	endtask
	task automatic t_par;
		@(posedge i_clk) i_switch_bank_zero <= 8'h80;
		cyc(16'h0000, 8'h07, 1, 0, 0);
		check("wr a", {o_ram_bank_a_select, o_ram_bank_b_select, o_parity_write_a, o_parity_write_b, o_parity_bit}, 8'h15);
		check("cfg", {o_parity_enable, o_bootstrap_enable}, 8'h02);
		cyc(16'h4000, 8'h03, 1, 0, 0);
		check("wr b", {o_ram_bank_a_select, o_ram_bank_b_select, o_parity_write_a, o_parity_write_b, o_parity_bit}, 8'h0A);
		cyc(16'h0000, 8'h07, 0, 1, 1);
		cyc(16'h4000, 8'h03, 0, 1, 1);
		check("good", o_parity_error, 8'h00);
		cyc(16'h4000, 8'h07, 0, 1, 1);
		check("bad", {o_parity_error, o_hold_request, o_halt_lamp}, 8'h07);
		repeat (3) cyc(16'h0000, 8'h00, 0, 0, 0);
		check("held", {o_parity_error, o_hold_request, o_halt_lamp}, 8'h07);
		@(posedge i_clk);
		do_reset;
		$display("parity test done");
	endtask
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		do_reset;
		t_switch;
		t_off;
		t_par;
		stop_test;
	end
endmodule // test_memory_parity_checker
